//--- sal_serial_adc_ctrl.sv
// Serial port and conversion sequencing of a 12-bit sampling converter.
// Assumes cs_n, sclk and din are synchronous to clk and sclk is far slower than clk.
`timescale 1ns/1ps
`default_nettype none
module sal_serial_adc_ctrl #(
  parameter int RES_W = sal_pkg::RES_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  output logic powered,
  output logic sample_en,
  output logic hold,
  output logic bias_en,
  output logic conv_start,
  output sal_pkg::sal_cfg_s cfg,
  input wire logic res_valid,
  output logic res_ready,
  input wire logic [RES_W-1:0] res_data
);

  // Picks the bit launched on falling edge n of the result phase
  function automatic logic out_bit(input logic [RES_W-1:0] w, input logic [sal_pkg::CNT_W-1:0] n,
                                   input logic msb_only);
    logic [sal_pkg::CNT_W-1:0] idx;
    idx = '0;
    out_bit = 1'b0;
    if (n >= sal_pkg::FALL_MSB && n <= sal_pkg::FALL_LAST) begin
      idx = sal_pkg::FALL_LAST - n;
      out_bit = w[idx[3:0]];
    end else if (!msb_only && n > sal_pkg::FALL_LAST && n <= sal_pkg::FALL_REV_END) begin
      idx = n - sal_pkg::FALL_LAST;
      out_bit = w[idx[3:0]];
    end
  endfunction

  sal_pkg::sal_state_e state_reg;
  sal_pkg::sal_cfg_s cfg_reg;
  logic sclk_q;
  logic [1:0] rcnt_reg;
  logic [sal_pkg::CNT_W-1:0] fcnt_reg;
  logic [RES_W-1:0] word_reg;
  logic dout_reg, oe_reg, powered_reg, sample_reg, hold_reg, start_reg;
  // Two-entry result buffer; holds words while the serial side is busy
  logic [RES_W-1:0] buf_mem [0:sal_pkg::BUF_DEPTH-1];
  logic wr_ptr, rd_ptr;
  logic [1:0] buf_cnt;

  // Edge detection and per-edge decode; nothing but the buffer push acts while chip select is high
  wire active = !cs_n;
  wire rise = active && sclk && !sclk_q;
  wire fall = active && !sclk && sclk_q;
  wire [sal_pkg::CNT_W-1:0] fcnt_inc = (fcnt_reg == sal_pkg::FALL_SAT) ? fcnt_reg : fcnt_reg + 6'h01;
  wire counting = state_reg != sal_pkg::SAL_WAIT_START;
  wire take_line = fall && counting && fcnt_inc == sal_pkg::FALL_DRIVE;
  wire load_word = fall && counting && fcnt_inc == sal_pkg::FALL_MSB;
  wire conv_done = fall && counting && fcnt_inc == sal_pkg::FALL_LAST;
  wire buf_empty = buf_cnt == 2'h0;
  wire pop = load_word && !buf_empty;
  wire push = res_valid && res_ready;
  wire [RES_W-1:0] head = buf_mem[rd_ptr];
  wire [RES_W-1:0] cur_word = load_word ? (buf_empty ? '0 : head) : word_reg;
  wire dout_next = out_bit(cur_word, fcnt_inc, cfg_reg.bit_order_select);

  assign res_ready = buf_cnt != 2'h2;
  assign dout = dout_reg;
  assign dout_oe = oe_reg;
  assign powered = powered_reg;
  assign sample_en = sample_reg;
  assign hold = hold_reg;
  assign bias_en = hold_reg;  // Bias and comparator live only during hold
  assign conv_start = start_reg;
  assign cfg = cfg_reg;

  // Buffer keeps its words across frames so a late result is not dropped
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      if (push) begin
        buf_mem[wr_ptr] <= res_data;
        wr_ptr <= !wr_ptr;
      end
      if (pop) begin
        rd_ptr <= !rd_ptr;
      end
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  // Power follows chip select directly
  always_ff @(posedge clk) begin
    if (reset) begin
      powered_reg <= 1'b0;
      sclk_q <= 1'b0;
    end else begin
      powered_reg <= !cs_n;
      sclk_q <= sclk;
    end
  end

  // Serial sequencer; chip select high acts as a reset of the frame
  always_ff @(posedge clk) begin
    if (reset || cs_n) begin
      state_reg <= sal_pkg::SAL_WAIT_START;
      cfg_reg <= sal_pkg::CFG_RESET;
      rcnt_reg <= 2'h0;
      fcnt_reg <= '0;
      word_reg <= '0;
      dout_reg <= 1'b0;
      oe_reg <= 1'b0;
      sample_reg <= 1'b0;
      hold_reg <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      start_reg <= take_line;
      if (rise) begin
        case (state_reg)
          sal_pkg::SAL_WAIT_START: begin
            if (din) begin
              state_reg <= sal_pkg::SAL_CONFIG;
            end
          end
          sal_pkg::SAL_CONFIG: begin
            rcnt_reg <= rcnt_reg + 2'h1;
            if (rcnt_reg == sal_pkg::RISE_MODE) begin
              cfg_reg.input_mode_select <= din;
            end
            if (rcnt_reg == sal_pkg::RISE_CHAN) begin
              cfg_reg.channel_select <= din;
              sample_reg <= 1'b1;
            end
            if (rcnt_reg == sal_pkg::RISE_ORDER) begin
              cfg_reg.bit_order_select <= din;
              state_reg <= sal_pkg::SAL_XFER;
            end
          end
          sal_pkg::SAL_XFER: begin
            state_reg <= sal_pkg::SAL_XFER;  // Further input ignored
          end
          default: begin
            state_reg <= sal_pkg::SAL_WAIT_START;
          end
        endcase
      end
      if (fall && counting) begin
        fcnt_reg <= fcnt_inc;
        dout_reg <= dout_next;
        if (load_word) begin
          word_reg <= cur_word;  // Empty buffer yields a zero word rather than a stall
        end
        if (take_line) begin
          oe_reg <= 1'b1;
          dout_reg <= 1'b0;
          sample_reg <= 1'b0;
          hold_reg <= 1'b1;
        end
        if (conv_done) begin
          hold_reg <= 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_line_takeover: assert property (take_line |=> dout_oe && !dout && hold)
    else $error("line not taken low on fourth falling edge");
  a_power_follow_cs: assert property (1 |=> powered == !$past(cs_n))
    else $error("power does not follow chip select");
  a_hold_start_edge: assert property ($rose(hold) |-> fcnt_reg == sal_pkg::FALL_DRIVE && !sample_en)
    else $error("hold began on wrong edge");
  a_conv_twelve_cycles: assert property ($fell(hold) && !$past(cs_n) |-> fcnt_reg == sal_pkg::FALL_LAST)
    else $error("conversion length not twelve cycles");
  a_auto_shutdown: assert property (conv_done |=> !bias_en ##1 !bias_en)
    else $error("bias still on after conversion");
  a_cs_high_quiet: assert property (cs_n |=> state_reg == sal_pkg::SAL_WAIT_START && !dout_oe && !hold)
    else $error("activity while chip select high");
  a_cfg_frozen: assert property (state_reg == sal_pkg::SAL_XFER && !cs_n |=> $stable(cfg_reg))
    else $error("config changed after three bits");
  a_zero_tail: assert property (counting && (fcnt_reg > sal_pkg::FALL_REV_END ||
    (cfg_reg.bit_order_select && fcnt_reg > sal_pkg::FALL_LAST)) |-> !dout)
    else $error("nonzero bit after result");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  a_sample_open: assert property ($rose(sample_en) |-> state_reg == sal_pkg::SAL_CONFIG && rcnt_reg == 2'h2)
    else $error("sampling opened on wrong bit");
endmodule
`default_nettype wire

//--- sal_pkg.sv
// Package for the shared-line serial converter control block.
// Assumes a single system clock; the serial clock is sampled as a data input.
package sal_pkg;
  // Result and edge bookkeeping
  localparam int RES_W = 12;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] FALL_DRIVE = 6'h04;   // Falling edge that takes the line and starts hold
  localparam logic [CNT_W-1:0] CONV_CYCLES = 6'h0c;  // Shift clock cycles per conversion
  localparam logic [CNT_W-1:0] FALL_MSB = FALL_DRIVE + 6'h01;
  localparam logic [CNT_W-1:0] FALL_LAST = FALL_DRIVE + CONV_CYCLES;
  localparam logic [CNT_W-1:0] FALL_REV_END = FALL_LAST + 6'h0b;
  localparam logic [CNT_W-1:0] FALL_SAT = 6'h3f;
  // Rising-edge index of configuration bits after the start bit
  localparam logic [1:0] RISE_MODE = 2'h0;
  localparam logic [1:0] RISE_CHAN = 2'h1;
  localparam logic [1:0] RISE_ORDER = 2'h2;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [1:0] {
    SAL_WAIT_START = 2'b00,
    SAL_CONFIG = 2'b01,
    SAL_XFER = 2'b10
  } sal_state_e;

  typedef struct packed {
    logic input_mode_select;  // 1 single-ended, 0 differential
    logic channel_select;     // Channel one, or positive side in differential mode
    logic bit_order_select;   // 1 zeros after result, 0 reversed copy follows
  } sal_cfg_s;

  localparam sal_cfg_s CFG_RESET = 3'h0;
endpackage

//--- sal_host_model.sv
// Host model: drives chip select, shift clock and its side of the shared data wire.
// Assumes the bench resolves the wire and that clk is far faster than sclk.
`timescale 1ns/1ps
`default_nettype none
module sal_host_model (
  input wire logic clk,
  input wire logic line,
  output logic cs_n,
  output logic sclk,
  output logic host_d,
  output logic host_oe,
  output logic got,
  output logic [29:0] cap
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    host_d = 1'b0;
    host_oe = 1'b1;
    got = 1'b0;
    cap = '0;
  end
  // One bit: launch after the fall, capture at the rise; four clk per half
  // Time is scaled down: the logic only counts edges, so the real rate ceiling is kept in spirit
  task automatic bit_io(input logic b, input logic rel);
    host_d <= b;
    repeat (4) @(posedge clk);
    sclk <= 1'b1;
    cap <= {cap[28:0], line};
    repeat (4) @(posedge clk);
    sclk <= 1'b0;
    if (rel) host_oe <= 1'b0;
  endtask
  // Whole frame; releasing the pin on the fall after the last config bit avoids a clash
  task automatic frame(input int zeros, input logic [2:0] c, input int n, input logic raise);
    logic [3:0] w;
    w = {1'b1, c};
    repeat (2) @(posedge clk);
    cs_n <= 1'b0;
    host_oe <= 1'b1;
    for (int i = 0; i < zeros; i++) bit_io(1'b0, 1'b0);
    for (int i = 3; i >= 0; i--) bit_io(w[i], i == 0);
    for (int i = 0; i < n; i++) bit_io(1'b0, 1'b0);
    @(posedge clk);
    cs_n <= raise;
    got <= (n == 30);
    @(posedge clk);
    got <= 1'b0;
  endtask
  // Random clock and data with chip select high
  task automatic noise(input int n);
    cs_n <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      sclk <= 1'($urandom_range(1));
      host_d <= 1'($urandom_range(1));
    end
    @(posedge clk);
    sclk <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- sal_serial_adc_ctrl_tb.sv
// Self-checking bench for the shared-line converter control block.
// Assumes the host model file and a 200 MHz clk.
`timescale 1ns/1ps
`default_nettype none
module sal_serial_adc_ctrl_tb;
  logic clk = 1'b0, reset = 1'b1, res_valid = 1'b0, flt = 1'b0, sclk_q = 1'b0;
  logic cs_n, sclk, host_d, host_oe, got, dout, dout_oe, powered, line;
  logic sample_en, hold, bias_en, conv_start, res_ready;
  logic [11:0] res_data = '0, w;
  logic [29:0] cap;
  logic [29:0] expq[$];
  sal_pkg::sal_cfg_s cfg;
  int err_total = 0, n_tests = 0, cyc = 0, hcnt = 0, seed;
  int clash = 0, scnt = 0, ccnt = 0;
  // Released wire flips every cycle so a missing drive never reads clean
  assign line = dout_oe ? dout : (host_oe ? host_d : flt);
  sal_serial_adc_ctrl sal_serial_adc_ctrl_inst (.clk(clk), .reset(reset), .cs_n(cs_n), .sclk(sclk), .din(line),
    .dout(dout), .dout_oe(dout_oe), .powered(powered), .sample_en(sample_en), .hold(hold), .bias_en(bias_en),
    .conv_start(conv_start), .cfg(cfg), .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
  sal_host_model sal_host_model_inst (.clk(clk), .line(line), .cs_n(cs_n), .sclk(sclk), .host_d(host_d),
    .host_oe(host_oe), .got(got), .cap(cap));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Null bit, result high first, then reversed copy or zeros
  function automatic logic [29:0] exp_bits(input logic [11:0] d, input logic ord);
    logic [29:0] e;
    e = '0;
    for (int i = 0; i < 12; i++) e[28-i] = d[11-i];
    for (int i = 1; i < 12; i++) if (!ord) e[17-i] = d[i];
    return e;
  endfunction
  task automatic chk(input logic [29:0] seen, input logic [29:0] want);
    n_tests++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic push(input logic [11:0] d, input int n);
    res_valid <= 1'b1;
    res_data <= d;
    repeat (n) @(posedge clk);
    res_valid <= 1'b0;
    @(posedge clk);
  endtask
  // Scoreboard: each finished frame takes the oldest note
  always @(posedge clk) begin
    flt <= ~flt;
    sclk_q <= sclk;
    if (sclk_q && !sclk && hold) hcnt++;
    // Sample window length in clk, start pulses, and both sides driving the wire at once
    if (sample_en) scnt++;
    if (conv_start) ccnt++;
    if (dout_oe && host_oe) clash++;
    if (got) chk(cap, expq.size() ? expq.pop_front() : 30'h3fffffff);
  end
  // Hang guard, well above the planned run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    seed = $urandom(32'hc78c);
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    sal_host_model_inst.noise(40);
    chk({27'h0, cfg}, 30'h0);
    for (int c = 0; c < 8; c++) begin
      w = 12'($urandom_range(4095));
      push(w, 1);
      expq.push_back(exp_bits(w, c[0]));
      hcnt = 0;
      scnt = 0;
      ccnt = 0;
      sal_host_model_inst.frame($urandom_range(3), 3'(c), 30, 1'b0);
      repeat (3) @(posedge clk);
      chk({27'h0, cfg}, 30'(c));
      chk(30'(hcnt), 30'h00c);
      chk(30'(scnt), 30'h00c);
      chk(30'(ccnt), 30'h001);
      chk({27'h0, hold, bias_en, powered}, 30'h001);
      sal_host_model_inst.noise(12);
      chk({28'h0, powered, dout_oe}, 30'h0);
    end
    // Two words fill the buffer; a third offer is refused
    w = 12'h5a3;
    push(w, 1);
    push(~w, 1);
    chk({29'h0, res_ready}, 30'h0);
    push(12'hfff, 3);
    expq.push_back(exp_bits(w, 1'b1));
    expq.push_back(exp_bits(~w, 1'b1));
    expq.push_back(30'h0);
    repeat (3) sal_host_model_inst.frame(0, 3'b101, 30, 1'b1);
    // Abort after the pop, then a clean frame
    push(12'h3c6, 1);
    sal_host_model_inst.frame(1, 3'b111, 5, 1'b1);
    repeat (3) @(posedge clk);
    chk({29'h0, dout_oe}, 30'h0);
    push(12'h81e, 1);
    expq.push_back(exp_bits(12'h81e, 1'b0));
    sal_host_model_inst.frame(2, 3'b010, 30, 1'b1);
    repeat (4) @(posedge clk);
    chk(30'(expq.size()), 30'h0);
    chk(30'(clash), 30'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
